//--- verilog/mcms_pkg.sv
// Constants and types shared by the machine-cycle sequencer and its state generator
package mcms_pkg;
  // =========================================================
  // Clock and state timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned STATES_PER_CYCLE = 4;
  localparam int unsigned STATE_TIME_NS = 100;
  localparam int unsigned STATE_CLKS = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =========================================================
  // Clock control register fields
  localparam int unsigned CCR_STRETCH_LSB = 0;
  localparam int unsigned CCR_STRETCH_MSB = 2;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [7:0] CCR_RESET = 8'h01;

  // =========================================================
  // External data move timing
  localparam logic [3:0] XDM_BASE_CYCLES = 4'h2;
  localparam logic [5:0] STROBE_START_S0 = 6'h01;
  localparam logic [5:0] STROBE_START_SN = 6'h02;
  localparam logic [5:0] STROBE_WIDTH_S0 = 6'h02;
  localparam logic [5:0] STROBE_STEP = 6'h04;

  // =========================================================
  // Opcode classes
  localparam logic [7:0] OP_XDM_READ = 8'he0;
  localparam logic [7:0] OP_XDM_WRITE = 8'hf0;
  localparam logic [4:0] OP_BRANCH_LOW = 5'h02;
  localparam logic [3:0] MAX_INSTR_CYCLES = 4'h5;

  // =========================================================
  // State encodings
  typedef enum logic [3:0] {
    MCMS_C1 = 4'h1,
    MCMS_C2 = 4'h2,
    MCMS_C3 = 4'h4,
    MCMS_C4 = 4'h8
  } mcms_state_t;

  typedef enum logic [2:0] {
    MCMS_FETCH = 3'h1,
    MCMS_EXEC = 3'h2,
    MCMS_XACC = 3'h4
  } mcms_mode_t;
endpackage

//--- verilog/mcms_state_gen.sv
// Four-state machine-cycle generator, with a falling-edge copy of the state
`timescale 1ns/1ps
module mcms_state_gen (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  output mcms_pkg::mcms_state_t o_state,
  output mcms_pkg::mcms_state_t o_state_neg
);
  import mcms_pkg::*;

  mcms_state_t state_ff;
  mcms_state_t nxt_state;
  mcms_state_t state_neg_ff;

  // =========================================================
  // Strict C1..C4 rotation
  always_comb begin
    case (state_ff)
      MCMS_C1: nxt_state = MCMS_C2;
      MCMS_C2: nxt_state = MCMS_C3;
      MCMS_C3: nxt_state = MCMS_C4;
      MCMS_C4: nxt_state = MCMS_C1;
      default: nxt_state = MCMS_C1; // Recover from a broken code
    endcase
  end

  // Rising edge advances the state
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= MCMS_C1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Mid-state copy on the falling edge; needs a near 50% duty clock
  always_ff @(negedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_neg_ff <= MCMS_C1;
    end else begin
      state_neg_ff <= state_ff;
    end
  end

  assign o_state = state_ff;
  assign o_state_neg = state_neg_ff;
endmodule // mcms_state_gen

//--- verilog/mcms_core.sv
// Machine-cycle sequencer with stretched external data move timing
//
// Contract
// - Each machine cycle is four one-clock states, C1 then C2, C3, C4.
// - Internal state timing uses both rising and falling clock edges.
// - At most one opcode fetch per machine cycle.
// - Jumps and calls take one extra machine cycle for the target; the code adds none when the base is already five.
// - All 256 opcodes decode; 128 finish in one machine cycle.
// - Instructions last one to five cycles; data move set by stretch.
// - Data move: normal fetch cycle, then address driven and access done.
// - Stretch is clock control bits 2..0; values 0..7 give 2..9 cycles.
// - Stretch resets to one, so a data move takes three cycles.
// - Strobe width 2 clocks at zero, else four clocks per stretch step.
// - Stretch touches only the data move; CPU state held meanwhile.
`timescale 1ns/1ps
module mcms_core #(
  parameter int ADDR_W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_xd_din,
  input wire logic i_ccr_wr,
  input wire logic [7:0] i_ccr_wdata,
  input wire logic [ADDR_W-1:0] i_xd_addr,
  input wire logic [7:0] i_xd_wdata,
  output mcms_pkg::mcms_state_t o_state,
  output mcms_pkg::mcms_state_t o_state_neg,
  output logic o_fetch,
  output logic o_instr_done,
  output logic o_cpu_hold,
  output logic [7:0] o_ccr_rdata,
  output logic [ADDR_W-1:0] o_xd_addr,
  output logic o_xd_rd_b,
  output logic o_xd_wr_b,
  output logic [7:0] o_xd_dout,
  output logic o_xd_oe_b,
  output logic [7:0] o_xd_rdata,
  output logic o_xd_rvalid
);
  import mcms_pkg::*;

  // =========================================================
  // Elaboration checks
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  // =========================================================
  // Decode helpers
  // Machine cycles of an ordinary opcode: lower half is single cycle
  function automatic logic [3:0] op_cycles(input logic [7:0] op);
    logic [3:0] base;
    base = 4'h1;
    if (op[7]) begin
      base = XDM_BASE_CYCLES + {2'h0, op[6:5]};
      if (op[4:0] == OP_BRANCH_LOW && base < MAX_INSTR_CYCLES) begin
        base = base + 4'h1;
      end
    end
    return base;
  endfunction

  function automatic logic is_xdm(input logic [7:0] op);
    return (op == OP_XDM_READ) || (op == OP_XDM_WRITE);
  endfunction

  // Strobe window in clocks counted from the first access clock
  function automatic logic strobe_on(input logic [5:0] k, input logic [2:0] s);
    logic [5:0] start;
    logic [5:0] width;
    start = (s == 3'h0) ? STROBE_START_S0 : STROBE_START_SN;
    width = (s == 3'h0) ? STROBE_WIDTH_S0 : 6'(STROBE_STEP * {3'h0, s});
    return (k >= start) && (k < 6'(start + width));
  endfunction

  // =========================================================
  // State generator
  mcms_state_t state;
  mcms_state_t state_neg;

  mcms_state_gen u_state_gen (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .o_state(state),
    .o_state_neg(state_neg)
  );

  wire logic at_c4 = (state == MCMS_C4);

  // =========================================================
  // Pin synchronisers; opcode and read data must hold from C2 to C4
  logic [7:0] op_meta_ff;
  logic [7:0] op_sync_ff;
  logic [7:0] din_meta_ff;
  logic [7:0] din_sync_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      op_meta_ff <= 8'h00;
      op_sync_ff <= 8'h00;
      din_meta_ff <= 8'h00;
      din_sync_ff <= 8'h00;
    end else begin
      op_meta_ff <= i_opcode;
      op_sync_ff <= op_meta_ff;
      din_meta_ff <= i_xd_din;
      din_sync_ff <= din_meta_ff;
    end
  end

  // =========================================================
  // Clock control register
  logic [7:0] ccr_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ccr_ff <= CCR_RESET;
    end else if (i_ccr_wr) begin
      ccr_ff <= i_ccr_wdata;
    end
  end

  wire logic [2:0] stretch = ccr_ff[CCR_STRETCH_MSB:CCR_STRETCH_LSB];

  // =========================================================
  // Instruction sequencing
  mcms_mode_t mode_ff;
  mcms_mode_t nxt_mode;
  logic [3:0] cyc_left_ff;
  logic [3:0] nxt_cyc_left;
  logic [2:0] s_lat_ff;
  logic [2:0] nxt_s;
  logic [5:0] acc_cnt_ff;
  logic [5:0] nxt_acc;
  logic xdm_write_ff;
  logic entering;

  // Next mode and remaining cycles, only moved at the close of C4
  always_comb begin
    nxt_mode = mode_ff;
    nxt_cyc_left = cyc_left_ff;
    entering = 1'b0;
    if (at_c4) begin
      case (mode_ff)
        MCMS_FETCH: begin
          if (is_xdm(op_sync_ff)) begin
            nxt_mode = MCMS_XACC;
            nxt_cyc_left = 4'h1 + {1'b0, stretch};
            entering = 1'b1;
          end else if (op_cycles(op_sync_ff) > 4'h1) begin
            nxt_mode = MCMS_EXEC;
            nxt_cyc_left = op_cycles(op_sync_ff) - 4'h1;
          end else begin
            nxt_mode = MCMS_FETCH;
            nxt_cyc_left = 4'h0;
          end
        end
        MCMS_EXEC, MCMS_XACC: begin
          nxt_cyc_left = cyc_left_ff - 4'h1;
          nxt_mode = (cyc_left_ff == 4'h1) ? MCMS_FETCH : mode_ff;
        end
        default: begin
          nxt_mode = MCMS_FETCH;
          nxt_cyc_left = 4'h0;
        end
      endcase
    end
    nxt_s = entering ? stretch : s_lat_ff;
    nxt_acc = entering ? 6'h00 : 6'(acc_cnt_ff + 6'h01);
  end

  // Mode, cycle count and stretch snapshot
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff <= MCMS_FETCH;
      cyc_left_ff <= 4'h0;
      s_lat_ff <= STRETCH_RESET;
      acc_cnt_ff <= 6'h00;
      xdm_write_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      cyc_left_ff <= nxt_cyc_left;
      s_lat_ff <= nxt_s;
      acc_cnt_ff <= (nxt_mode == MCMS_XACC) ? nxt_acc : 6'h00;
      if (entering) begin
        xdm_write_ff <= (op_sync_ff == OP_XDM_WRITE);
      end
    end
  end

  // =========================================================
  // Sequencer status outputs
  logic fetch_ff;
  logic done_ff;
  logic hold_ff;

  // Fetch only in C1 of a fetch cycle, so never twice per cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fetch_ff <= 1'b0;
      done_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      fetch_ff <= (nxt_mode == MCMS_FETCH) && at_c4;
      done_ff <= at_c4 && (nxt_mode == MCMS_FETCH);
      hold_ff <= (nxt_mode == MCMS_XACC) && (nxt_acc >= 6'd4);
    end
  end

  // =========================================================
  // External data bus
  logic [ADDR_W-1:0] addr_ff;
  logic rd_b_ff;
  logic wr_b_ff;
  logic [7:0] dout_ff;
  logic oe_b_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic strobe_nxt;

  assign strobe_nxt = (nxt_mode == MCMS_XACC) && strobe_on(nxt_acc, nxt_s);

  // Address and write data captured as the access cycle begins
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_ff <= '0;
      dout_ff <= 8'h00;
      oe_b_ff <= 1'b1;
    end else begin
      if (entering) begin
        addr_ff <= i_xd_addr;
        dout_ff <= i_xd_wdata;
      end
      oe_b_ff <= !((nxt_mode == MCMS_XACC) && (entering ? op_sync_ff == OP_XDM_WRITE
                                                        : xdm_write_ff));
    end
  end

  // Strobes are registered so they never glitch at state boundaries
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_b_ff <= 1'b1;
      wr_b_ff <= 1'b1;
    end else begin
      rd_b_ff <= !(strobe_nxt && !(entering ? op_sync_ff == OP_XDM_WRITE : xdm_write_ff));
      wr_b_ff <= !(strobe_nxt && (entering ? op_sync_ff == OP_XDM_WRITE : xdm_write_ff));
    end
  end

  // Read data taken two clocks after the read strobe rises (sync delay)
  logic [1:0] rd_end_ff;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_end_ff <= 2'h0;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rd_end_ff <= {rd_end_ff[0], !rd_b_ff && strobe_nxt == 1'b0};
      rvalid_ff <= rd_end_ff[1];
      if (rd_end_ff[1]) begin
        rdata_ff <= din_sync_ff;
      end
    end
  end

  // =========================================================
  // Output drive
  assign o_state = state;
  assign o_state_neg = state_neg;
  assign o_fetch = fetch_ff;
  assign o_instr_done = done_ff;
  assign o_cpu_hold = hold_ff;
  assign o_ccr_rdata = ccr_ff;
  assign o_xd_addr = addr_ff;
  assign o_xd_rd_b = rd_b_ff;
  assign o_xd_wr_b = wr_b_ff;
  assign o_xd_dout = dout_ff;
  assign o_xd_oe_b = oe_b_ff;
  assign o_xd_rdata = rdata_ff;
  assign o_xd_rvalid = rvalid_ff;
endmodule // mcms_core

//--- bench/mcms_xmem_model.sv
// Behavioural external data memory answering the sequencer strobes
`timescale 1ns/1ps
module mcms_xmem_model #(
  parameter int ADDR_W = 16
) (
  input wire logic i_ref_clk,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_rd_b,
  input wire logic i_wr_b,
  input wire logic i_oe_b,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_ff [256];
  int hold_ff = 0;
  initial begin
    o_rdata = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem_ff[i] = 8'(i) ^ 8'h5a;
    end
  end
  // =========================================================
  // Read data kept four clocks past strobe rise, then scrambled so stale data never passes
  always @(posedge i_ref_clk) begin
    if (!i_wr_b && !i_oe_b) begin
      mem_ff[i_addr[7:0]] <= i_wdata;
    end
    if (!i_rd_b) begin
      o_rdata <= mem_ff[i_addr[7:0]];
      hold_ff <= 3;
    end else if (hold_ff > 0) begin
      hold_ff <= hold_ff - 1;
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule // mcms_xmem_model

//--- bench/mcms_core_properties.sv
// Port-level assertions for the machine-cycle sequencer
`timescale 1ns/1ps
module mcms_core_chk
  import mcms_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ccr_wr,
  input wire logic [7:0] i_ccr_wdata,
  input wire mcms_pkg::mcms_state_t o_state,
  input wire mcms_pkg::mcms_state_t o_state_neg,
  input wire logic o_fetch,
  input wire logic o_instr_done,
  input wire logic o_cpu_hold,
  input wire logic [7:0] o_ccr_rdata,
  input wire logic [ADDR_W-1:0] o_xd_addr,
  input wire logic o_xd_rd_b,
  input wire logic o_xd_wr_b,
  input wire logic o_xd_rvalid
);
  logic first_ff;
  logic fch_ff;
  logic [2:0] snap_ff;
  logic [4:0] low_ff;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // =========================================================
  // Stretch seen at fetch C4, strobe low-time count
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      first_ff <= 1'b1;
      fch_ff <= 1'b1;
      snap_ff <= STRETCH_RESET;
      low_ff <= 5'h00;
    end else begin
      if (o_state == MCMS_C1) begin
        first_ff <= 1'b0;
        fch_ff <= o_fetch | first_ff;
      end
      if (o_state == MCMS_C4 && fch_ff) begin
        snap_ff <= o_ccr_rdata[2:0];
      end
      low_ff <= (!o_xd_rd_b || !o_xd_wr_b) ? low_ff + 5'h01 : 5'h00;
    end
  end
  property p_seq;
    1'b1 |=> o_state == mcms_state_t'({$past(o_state[2:0]), $past(o_state[3])});
  endproperty
  a_seq: assert property (p_seq) else $error("state order broken");
  property p_neg;
    o_state_neg == o_state;
  endproperty
  a_neg: assert property (p_neg) else $error("falling-edge state lags");
  property p_fetch;
    o_fetch |-> o_state == MCMS_C1 ##1 !o_fetch [*3];
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch misplaced");
  property p_len;
    o_fetch |-> o_instr_done ##[4:36] o_fetch;
  endproperty
  a_len: assert property (p_len) else $error("instruction too long");
  property p_spos;
    ($fell(o_xd_rd_b) || $fell(o_xd_wr_b)) |-> o_state inside {MCMS_C2, MCMS_C3};
  endproperty
  a_spos: assert property (p_spos) else $error("strobe start misplaced");
  property p_width;
    ($rose(o_xd_rd_b) || $rose(o_xd_wr_b)) |-> low_ff == (snap_ff == 3'h0 ? 5'h02 : {snap_ff, 2'h0});
  endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
  property p_hold;
    o_cpu_hold |-> !o_fetch && $stable(o_xd_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("hold with fetch");
  property p_ccr;
    i_ccr_wr |=> o_ccr_rdata == $past(i_ccr_wdata);
  endproperty
  a_ccr: assert property (p_ccr) else $error("control write lost");
  property p_rv;
    $rose(o_xd_rd_b) |-> ##[1:6] o_xd_rvalid;
  endproperty
  a_rv: assert property (p_rv) else $error("read data missing");
endmodule // mcms_core_chk
bind mcms_core mcms_core_chk #(.ADDR_W(ADDR_W)) u_chk (.i_ref_clk(i_ref_clk),
  .i_rst_b(i_rst_b), .i_ccr_wr(i_ccr_wr), .i_ccr_wdata(i_ccr_wdata), .o_state(o_state),
  .o_state_neg(o_state_neg), .o_fetch(o_fetch), .o_instr_done(o_instr_done),
  .o_cpu_hold(o_cpu_hold), .o_ccr_rdata(o_ccr_rdata), .o_xd_addr(o_xd_addr),
  .o_xd_rd_b(o_xd_rd_b), .o_xd_wr_b(o_xd_wr_b), .o_xd_rvalid(o_xd_rvalid));

//--- bench/tb_mcms_core.sv
// Self-checking bench: sequencer against an integer model of cycle counts and moves
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module tb_mcms_core;
  import mcms_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ccr_wr = 1'b0;
  logic [7:0] i_opcode = 8'h00, i_ccr_wdata = 8'h00, i_xd_wdata = 8'h00, i_xd_din;
  logic [15:0] i_xd_addr = 16'h0000, o_xd_addr;
  mcms_state_t o_state, o_state_neg;
  logic o_fetch, o_instr_done, o_cpu_hold, o_xd_rd_b, o_xd_wr_b, o_xd_oe_b, o_xd_rvalid;
  logic [7:0] o_ccr_rdata, o_xd_dout, o_xd_rdata, ccr_m;
  int n_mismatch = 0, check_count = 0, s_m = 1;
  // Expected read bytes; a short read hands its data over in the next instruction
  int rd_q[$];
  int mem_m [256];
  always #50 i_ref_clk = ~i_ref_clk;
  mcms_core u_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_opcode(i_opcode),
    .i_xd_din(i_xd_din), .i_ccr_wr(i_ccr_wr), .i_ccr_wdata(i_ccr_wdata), .i_xd_addr(i_xd_addr),
    .i_xd_wdata(i_xd_wdata), .o_state(o_state), .o_state_neg(o_state_neg), .o_fetch(o_fetch),
    .o_instr_done(o_instr_done), .o_cpu_hold(o_cpu_hold), .o_ccr_rdata(o_ccr_rdata),
    .o_xd_addr(o_xd_addr), .o_xd_rd_b(o_xd_rd_b), .o_xd_wr_b(o_xd_wr_b), .o_xd_dout(o_xd_dout),
    .o_xd_oe_b(o_xd_oe_b), .o_xd_rdata(o_xd_rdata), .o_xd_rvalid(o_xd_rvalid));
  mcms_xmem_model u_mem (.i_ref_clk(i_ref_clk), .i_addr(o_xd_addr), .i_rd_b(o_xd_rd_b),
    .i_wr_b(o_xd_wr_b), .i_oe_b(o_xd_oe_b), .i_wdata(o_xd_dout), .o_rdata(i_xd_din));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // =========================================================
  // One instruction from its fetch C1 to the next; junk opcode shown outside fetch
  task automatic run_op(input logic [7:0] op, input int ccr_new);
    int n, c, lr, lw, lh, w, rd_e;
    begin
      if (op != OP_XDM_READ) begin
        i_xd_addr = 16'($urandom);
      end
      i_xd_wdata = 8'($urandom);
      i_opcode = op;
      n = op[7] ? 2 + op[6:5] + (op[4:0] == OP_BRANCH_LOW) : 1;
      n = (n > 5) ? 5 : n;
      if (op == OP_XDM_READ || op == OP_XDM_WRITE) begin
        n = 2 + s_m;
      end
      w = (s_m == 0) ? 2 : 4 * s_m;
      if (op == OP_XDM_READ) begin
        rd_q.push_back(mem_m[i_xd_addr[7:0]]);
      end
      c = 0;
      lr = 0;
      lw = 0;
      lh = 0;
      do begin
        @(negedge i_ref_clk);
        c++;
        lr += !o_xd_rd_b;
        lw += !o_xd_wr_b;
        lh += o_cpu_hold;
        if (o_xd_rvalid) begin
          rd_e = (rd_q.size() > 0) ? rd_q.pop_front() : 32'h100;
          `CHK("rdata", rd_e, o_xd_rdata)
        end
        if (c == 5) begin
          i_opcode = 8'($urandom);
        end
        i_ccr_wr = (c == 9 && ccr_new >= 0);
        if (i_ccr_wr) begin
          i_ccr_wdata = {5'($urandom), 3'(ccr_new)};
          ccr_m = i_ccr_wdata;
        end
      end while (!o_fetch && c < 40);
      `CHK("len", 4 * n, c)
      `CHK("wr_w", (op == OP_XDM_WRITE) ? w : 0, lw)
      `CHK("rd_w", (op == OP_XDM_READ) ? w : 0, lr)
      `CHK("ccr", ccr_m, o_ccr_rdata)
      `CHK("hold", (op == OP_XDM_READ || op == OP_XDM_WRITE) ? 4 * s_m : 0, lh)
      if (ccr_new >= 0) begin
        s_m = ccr_new;
      end
      if (op == OP_XDM_WRITE) begin
        mem_m[i_xd_addr[7:0]] = i_xd_wdata;
        `CHK("addr", i_xd_addr, o_xd_addr)
      end
      if (op != OP_XDM_READ || s_m != 0) begin
        `CHK("rvalid", 0, rd_q.size())
      end
    end
  endtask
  // =========================================================
  // Watchdog against a hung sequence
  initial begin
    #1_000_000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h05a0b558));
    ccr_m = CCR_RESET;
    for (int i = 0; i < 256; i++) begin
      mem_m[i] = i ^ 8'h5a;
    end
    repeat (16) @(negedge i_ref_clk);
    `CHK("ccr_rst", CCR_RESET, o_ccr_rdata)
    `CHK("st_rst", MCMS_C1, o_state)
    i_rst_b = 1'b1;
    run_op(OP_XDM_WRITE, -1);
    // Descending stretch keeps every carrier move long enough for a mid-access write
    for (int s = 7; s >= 0; s--) begin
      run_op(OP_XDM_WRITE, s);
      run_op(OP_XDM_WRITE, -1);
      run_op(OP_XDM_READ, -1);
    end
    for (int j = 0; j < 4; j++) begin
      run_op({1'b1, 2'(j), 5'h02}, -1);
    end
    for (int i = 0; i < 40; i++) begin
      run_op(8'($urandom), -1);
    end
    run_op(8'h00, -1);
    complete_run;
  end
endmodule // tb_mcms_core
